// *** src/iso_rx_context_match_filter.sv ***
// isochronous receive context start pointer and packet acceptance filter
`timescale 1ns/1ns
// What this block does
// (RULE1) each context shows a read-only first-descriptor address used on run
// (RULE2) four contexts, registers repeat every 32 bytes from base offsets
// (RULE3) tag enables in bits 31..28 accept tags 11b,10b,01b,00b, any mix
// (RULE4) match register bits 27 and 7 always read zero
// (RULE5) start-cycle field bits 26..12: two low seconds bits, 13-bit cycle
// (RULE6) with start-on-cycle enabled, accept only after timer equals field
// (RULE7) sync bits 11..8 compared to packet sync while descriptor waits 11b
// (RULE8) restrict on, tag01 enabled: tag01 needs top two sync bits 00b
// (RULE9) restrict off: acceptance by tag enables only
// (RULE10) channel field bits 5..0 selects the one accepted channel
// (RULE11) run set and cleared by software; device clears it only on reset
// (RULE12) active status shown while the context processes descriptors
// (RULE13) packets with other channel or disabled tag are discarded
module iso_rx_context_match_filter (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic softReset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iso_rx_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire iso_rx_pkg::iso_pkt_t rxPacket,
	input wire iso_rx_pkg::cycle_timer_t cycleTimer,
	input wire iso_rx_pkg::desc_load_t descLoad,
	input wire logic [iso_rx_pkg::NUM_CTX-1:0] waitSync,
	output logic [iso_rx_pkg::NUM_CTX-1:0] packetAccept,
	output logic [iso_rx_pkg::NUM_CTX-1:0] contextRun,
	output logic [iso_rx_pkg::NUM_CTX-1:0] contextActive
);
	import iso_rx_pkg::*;

	// address decode, shared by the read path and the write path
	function automatic reg_sel_t decodeAddr(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		logic [15:0] base;
		s.ctx = a[CTX_SEL_LSB+1:CTX_SEL_LSB];
		base = a & ~CTX_SEL_MASK;
		if (base == OFF_CONTROL) begin
			s.kind = REG_CONTROL;
		end else if (base == OFF_DESC_START) begin
			s.kind = REG_DESC_START;
		end else if (base == OFF_MATCH) begin
			s.kind = REG_MATCH;
		end else begin
			s.kind = REG_NONE;
		end
		return s;
	endfunction

	logic [31:0] matchReg [NUM_CTX];
	logic [31:0] descStart [NUM_CTX];
	logic [NUM_CTX-1:0] runBit;
	logic [NUM_CTX-1:0] startOnCycle;
	logic [NUM_CTX-1:0] started;
	logic [NUM_CTX-1:0] timerHit;
	logic [NUM_CTX-1:0] next_accept;
	logic resetNow;
	reg_sel_t setupSel;
	reg_sel_t accessSel;
	logic writeNow;
	logic [31:0] readValue;

	assign resetNow = !rst_b || softReset;
	assign setupSel = decodeAddr(paddr);
	assign accessSel = setupSel;
	// the write lands on the access cycle in which pready is high
	assign writeNow = psel && penable && pready && pwrite;

	// apb: no wait state; pready and prdata come from flops set in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !pready;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !pready && setupSel.kind == REG_NONE;
		end
	end

	always_comb begin
		readValue = 32'h0000_0000;
		unique case (setupSel.kind)
			REG_CONTROL: begin
				readValue[CTL_START_ON_CYCLE] = startOnCycle[setupSel.ctx];
				readValue[CTL_RUN] = runBit[setupSel.ctx];
				readValue[CTL_ACTIVE] = contextActive[setupSel.ctx];
			end
			REG_DESC_START: begin
				readValue = descStart[setupSel.ctx]; // [RULE1]
			end
			REG_MATCH: begin
				readValue = matchReg[setupSel.ctx] & MATCH_WRITE_MASK; // [RULE4]
			end
			REG_NONE: begin
				readValue = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !pready && !pwrite) begin
			prdata <= readValue;
		end else if (!psel) begin
			prdata <= 32'h0000_0000;
		end
	end

	genvar n;
	generate
		for (n = 0; n < NUM_CTX; n++) begin : g_ctx
			logic hitCtx;
			logic tagOk;
			logic chanOk;
			logic syncOk;
			logic [MF_START_HI-MF_START_LO:0] startField;

			assign hitCtx = writeNow && accessSel.ctx == 2'(n); // [RULE2]

			// match register: software owned, reserved bits never stored
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					matchReg[n] <= MATCH_RESET;
				end else if (hitCtx && accessSel.kind == REG_MATCH) begin
					matchReg[n] <= pwdata & MATCH_WRITE_MASK; // [RULE4]
				end
			end

			// first descriptor address, loaded by the descriptor engine only
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					descStart[n] <= DESC_START_RESET;
				end else if (descLoad.load && descLoad.ctx == 2'(n)) begin
					descStart[n] <= descLoad.addr; // [RULE1]
				end
			end

			// run changes only by software write or by a reset
			always_ff @(posedge clk_sys) begin
				if (resetNow) begin
					runBit[n] <= 1'b0; // [RULE11]
				end else if (hitCtx && accessSel.kind == REG_CONTROL) begin
					runBit[n] <= pwdata[CTL_RUN]; // [RULE11]
				end
			end

			assign startField = matchReg[n][MF_START_HI:MF_START_LO];
			assign timerHit[n] = startField == // [RULE5]
				{cycleTimer.timerSecondsCount[1:0],
				cycleTimer.timerCycleIndex}; // [RULE6]

			// start-on-cycle enable drops once the start cycle is reached while run is set;
			// a software write in the same cycle wins over that clear
			always_ff @(posedge clk_sys) begin
				if (resetNow) begin
					startOnCycle[n] <= 1'b0;
				end else if (hitCtx && accessSel.kind == REG_CONTROL) begin
					startOnCycle[n] <= pwdata[CTL_START_ON_CYCLE];
				end else if (runBit[n] && timerHit[n]) begin
					startOnCycle[n] <= 1'b0; // [RULE6]
				end
			end

			// a running context starts at once, or at its start cycle
			always_ff @(posedge clk_sys) begin
				if (resetNow || !runBit[n]) begin
					started[n] <= 1'b0;
				end else if (!startOnCycle[n] || timerHit[n]) begin
					started[n] <= 1'b1; // [RULE6]
				end
			end

			always_ff @(posedge clk_sys) begin
				if (resetNow) begin
					contextActive[n] <= 1'b0;
				end else begin
					contextActive[n] <= runBit[n] && started[n]; // [RULE12]
				end
			end

			always_comb begin
				unique case (rxPacket.tag)
					2'b11: tagOk = matchReg[n][MF_TAG_11]; // [RULE3]
					2'b10: tagOk = matchReg[n][MF_TAG_10]; // [RULE3]
					2'b01: begin
						// restriction applies only to tag 01b
						tagOk = matchReg[n][MF_TAG_01] && // [RULE3]
							(!matchReg[n][MF_SYNC_RESTRICT] || // [RULE9]
							rxPacket.sync[3:2] == 2'b00); // [RULE8]
					end
					2'b00: tagOk = matchReg[n][MF_TAG_00]; // [RULE3]
				endcase
			end

			assign chanOk = rxPacket.channel ==
				matchReg[n][MF_CHAN_HI:MF_CHAN_LO]; // [RULE10]
			// while the descriptor waits for sync, other sync values are
			// dropped so capture starts on the intended packet
			assign syncOk = !waitSync[n] ||
				rxPacket.sync == matchReg[n][MF_SYNC_HI:MF_SYNC_LO]; // [RULE7]
			assign next_accept[n] = rxPacket.valid && contextActive[n] &&
				chanOk && tagOk && syncOk; // [RULE13]
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (resetNow) begin
			packetAccept <= '0;
		end else begin
			packetAccept <= next_accept; // [RULE13]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (resetNow) begin
			contextRun <= '0;
		end else begin
			contextRun <= runBit;
		end
	end

endmodule

// *** include/iso_rx_pkg.sv ***
// shared constants and types for the isochronous receive context filter
package iso_rx_pkg;

	localparam int NUM_CTX = 4;
	localparam int ADDR_W = 16;

	// byte addresses of context 0; context n adds n times the stride
	localparam logic [15:0] CTX_STRIDE = 16'h0020;
	localparam logic [15:0] CTX_SEL_MASK = 16'h0060;
	localparam int CTX_SEL_LSB = 5;
	localparam logic [15:0] OFF_CONTROL = 16'h0400;
	localparam logic [15:0] OFF_DESC_START = 16'h040C;
	localparam logic [15:0] OFF_MATCH = 16'h410C;

	// control register fields
	localparam int CTL_START_ON_CYCLE = 29;
	localparam int CTL_RUN = 15;
	localparam int CTL_ACTIVE = 10;

	// match register fields
	localparam int MF_TAG_11 = 31;
	localparam int MF_TAG_10 = 30;
	localparam int MF_TAG_01 = 29;
	localparam int MF_TAG_00 = 28;
	localparam int MF_START_HI = 26;
	localparam int MF_START_LO = 12;
	localparam int MF_SYNC_HI = 11;
	localparam int MF_SYNC_LO = 8;
	localparam int MF_SYNC_RESTRICT = 6;
	localparam int MF_CHAN_HI = 5;
	localparam int MF_CHAN_LO = 0;
	// bits 27 and 7 are reserved and read as zero
	localparam logic [31:0] MATCH_WRITE_MASK = 32'hF7FF_FF7F;

	// values after reset
	localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
	localparam logic [31:0] DESC_START_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		REG_NONE,
		REG_CONTROL,
		REG_DESC_START,
		REG_MATCH
	} reg_kind_t;

	typedef struct packed {
		reg_kind_t kind;
		logic [1:0] ctx;
	} reg_sel_t;

	// one received isochronous packet header, valid for one cycle
	typedef struct packed {
		logic valid;
		logic [5:0] channel;
		logic [1:0] tag;
		logic [3:0] sync;
	} iso_pkt_t;

	// cycle timer value
	typedef struct packed {
		logic [6:0] timerSecondsCount;
		logic [12:0] timerCycleIndex;
	} cycle_timer_t;

	// descriptor engine loads the first descriptor address of a context
	typedef struct packed {
		logic load;
		logic [1:0] ctx;
		logic [31:0] addr;
	} desc_load_t;

endpackage

// *** tb/iso_rx_checker.sv ***
// port assertions for the receive context filter
`timescale 1ns/1ns
module iso_rx_checker (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic softReset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iso_rx_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire iso_rx_pkg::iso_pkt_t rxPacket,
	input wire logic [iso_rx_pkg::NUM_CTX-1:0] packetAccept,
	input wire logic [iso_rx_pkg::NUM_CTX-1:0] contextRun,
	input wire logic [iso_rx_pkg::NUM_CTX-1:0] contextActive
);
	import iso_rx_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence setup_s; psel && !penable; endsequence
	sequence match_rd_s;
		pready && !pwrite && (paddr & ~CTX_SEL_MASK) == OFF_MATCH;
	endsequence
	apb_answer_a: assert property (setup_s |=> pready)
		else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("lone slverr");
	match_resvd_a: assert property (match_rd_s |->
		prdata[27] == 1'b0 && prdata[7] == 1'b0) else $error("reserved set");
	accept_cause_a: assert property (packetAccept != '0 |->
		$past(rxPacket.valid)) else $error("accept without packet");
	accept_active_a: assert property (
		(packetAccept & ~$past(contextActive)) == '0) else $error("idle accept");
	run_stop_a: assert property (
		(contextActive & ~contextRun & ~$past(contextRun)) == '0)
		else $error("active without run");
	soft_clear_a: assert property (softReset |-> ##2
		(contextRun == '0 && contextActive == '0)) else $error("soft reset");
endmodule

// *** tb/iso_link_model.sv ***
// link receive path and cycle timer model
`timescale 1ns/1ns
module iso_link_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	output iso_rx_pkg::iso_pkt_t rxPacket,
	output iso_rx_pkg::cycle_timer_t cycleTimer
);
	import iso_rx_pkg::*;
	initial rxPacket = '0;
	// cycle count rolls into the seconds count after 8000 cycles
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			cycleTimer <= '0;
		else if (cycleTimer.timerCycleIndex == 13'd7999)
			cycleTimer <= {cycleTimer.timerSecondsCount + 7'd1, 13'd0};
		else
			cycleTimer.timerCycleIndex <= cycleTimer.timerCycleIndex + 13'd1;
	end
	// header goes to its inverse once valid drops, never lingers
	task automatic send(input logic [5:0] ch, input logic [1:0] tg,
		input logic [3:0] sy);
		@(posedge clk_sys);
		rxPacket <= {1'b1, ch, tg, sy};
		@(posedge clk_sys);
		rxPacket <= {1'b0, ~ch, ~tg, ~sy};
	endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the receive context filter
`timescale 1ns/1ns
module testbench;
	import iso_rx_pkg::*;
	logic clk_sys, rst_b, softReset, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	iso_pkt_t rxPacket;
	cycle_timer_t cycleTimer;
	desc_load_t descLoad;
	logic [NUM_CTX-1:0] waitSync, packetAccept, contextRun, contextActive;
	// wait, channel, tag, sync, expected accept
	logic [13:0] pk [8] = '{14'h02E1, 14'h0360, 14'h0280, 14'h02C0,
		14'h02A7, 14'h02A8, 14'h22E6, 14'h22E1};
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	iso_link_model link (.clk_sys, .rst_b, .rxPacket, .cycleTimer);
	iso_rx_context_match_filter dut (.clk_sys, .rst_b, .softReset, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rxPacket, .cycleTimer, .descLoad, .waitSync, .packetAccept,
		.contextRun, .contextActive);
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		if (k >= 50)
			n_mismatch++;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done;
		end
	end
	initial begin
		{rst_b, softReset, psel, penable, pwrite, paddr} = '0;
		{pwdata, descLoad, waitSync} = '0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(0, OFF_MATCH, 0);
		chk("match reset", MATCH_RESET, rd);
		apb(1, OFF_MATCH + CTX_STRIDE, 32'hFFFF_FFFF);
		apb(0, OFF_MATCH + CTX_STRIDE, 0);
		chk("match bits", 32'hF7FF_FF7F, rd);
		descLoad <= '{1'b1, 2'd3, 32'h1234_5670};
		@(posedge clk_sys);
		descLoad.load <= 1'b0;
		apb(1, OFF_DESC_START + 16'h0060, 32'h0);
		apb(0, OFF_DESC_START + 16'h0060, 0);
		chk("desc start", 32'h1234_5670, rd);
		apb(0, 16'h0800, 0);
		chk("unmapped", 32'd1, {31'd0, err});
		apb(1, OFF_MATCH, 32'hA000_0045);
		apb(1, OFF_CONTROL, 32'h0000_8000);
		// active follows run two edges later; let it settle before the read
		repeat (2) @(posedge clk_sys);
		apb(0, OFF_CONTROL, 0);
		chk("control", 32'h0000_8400, rd);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			waitSync <= {3'd0, pk[i][13]};
			link.send(pk[i][12:7], pk[i][6:5], pk[i][4:1]);
			@(negedge clk_sys);
			chk("accept", {31'd0, pk[i][0]}, {28'd0, packetAccept});
		end
		apb(1, OFF_MATCH + CTX_STRIDE, 32'h0025_8000);
		apb(1, OFF_CONTROL + CTX_STRIDE, 32'h2000_8000);
		repeat (4) @(posedge clk_sys);
		chk("early", 32'd0, {31'd0, contextActive[1]});
		while (cycleTimer.timerCycleIndex < 13'd610)
			@(posedge clk_sys);
		chk("on cycle", 32'd1, {31'd0, contextActive[1]});
		softReset <= 1'b1;
		@(posedge clk_sys);
		softReset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("run", 32'd0, {28'd0, contextRun});
		apb(0, OFF_CONTROL, 0);
		chk("control", 32'd0, rd);
		test_done;
	end
endmodule
bind iso_rx_context_match_filter iso_rx_checker chk_i (.clk_sys, .rst_b,
	.softReset, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .rxPacket, .packetAccept, .contextRun, .contextActive);
